// file: wcb_pkg.sv
// shared constants, field layouts and carrier types of the waveform
// capture buffer; assumes a 200 MHz core clock and an spi master outside
package wcb_pkg;

   // memory geometry
   localparam int WCB_ADDR_W = 11;
   localparam int WCB_DEPTH = 2048;
   localparam logic [11:0] WCB_BUF_BASE = 12'h0800;
   localparam logic [10:0] WCB_RS_STEP = 11'h004;
   localparam logic [10:0] WCB_FR_STEP = 11'h008;
   localparam logic [10:0] WCB_RS_LAST_SET = 11'h7FC;
   localparam logic [2:0] WCB_RS_LAST_WORD = 3'h3;
   localparam logic [2:0] WCB_FR_LAST_WORD = 3'h6;
   localparam int WCB_SETS_PER_LINE_CYCLE = 64;

   // spi command header: address in [15:4], read flag in bit 3
   localparam int WCB_HDR_ADDR_MSB = 15;
   localparam int WCB_HDR_ADDR_LSB = 4;
   localparam int WCB_HDR_READ_BIT = 3;
   localparam logic [3:0] WCB_HDR_LAST_BIT = 4'hF;
   localparam logic [4:0] WCB_RS_LAST_BIT = 5'h0F;
   localparam logic [4:0] WCB_FR_LAST_BIT = 5'h1F;

   // capture type encodings
   localparam logic WCB_CAP_RESAMPLED = 1'b0;
   localparam logic WCB_CAP_FIXED = 1'b1;

   // burst channel select codes
   localparam logic [3:0] WCB_BURST_ALL = 4'h0;
   localparam logic [3:0] WCB_BURST_PH_A = 4'h1;
   localparam logic [3:0] WCB_BURST_PH_B = 4'h2;
   localparam logic [3:0] WCB_BURST_PH_C = 4'h3;
   localparam logic [3:0] WCB_BURST_NEUTRAL = 4'hE;
   localparam logic [3:0] WCB_BURST_SINGLE = 4'hF;

   // channel masks, bit index is burst order: ia va ib vb ic vc neutral
   localparam logic [6:0] WCB_MASK_ALL = 7'h7F;
   localparam logic [6:0] WCB_MASK_NO_NEUTRAL = 7'h3F;
   localparam logic [6:0] WCB_MASK_PH_A = 7'h03;
   localparam logic [6:0] WCB_MASK_PH_B = 7'h0C;
   localparam logic [6:0] WCB_MASK_PH_C = 7'h30;
   localparam logic [6:0] WCB_MASK_NEUTRAL = 7'h40;
   localparam logic [2:0] WCB_CH_NEUTRAL = 3'h6;
   localparam logic [10:0] WCB_NEUTRAL_WORD = 11'h003;

   // reset values
   localparam logic [11:0] WCB_LAST_ADDR_RESET = 12'h0000;
   localparam logic [11:0] WCB_TRIG_ADDR_RESET = 12'h0000;
   localparam logic [15:0] WCB_SPARE = 16'h0000;

   // one resampled sample set, all from the same instant
   typedef struct packed {
      logic [15:0] neutral;
      logic [15:0] vc;
      logic [15:0] ic;
      logic [15:0] vb;
      logic [15:0] ib;
      logic [15:0] va;
      logic [15:0] ia;
   } wcb_rs_set_t;

   // one fixed-rate sample set
   typedef struct packed {
      logic [31:0] neutral;
      logic [31:0] vc;
      logic [31:0] ic;
      logic [31:0] vb;
      logic [31:0] ib;
      logic [31:0] va;
      logic [31:0] ia;
   } wcb_fr_set_t;

   // buffer configuration bits
   typedef struct packed {
      logic capture_enable;
      logic capture_type_select;
      logic [1:0] fill_mode_select;
      logic [1:0] waveform_source_select;
      logic neutral_storage_enable;
      logic [3:0] burst_channel_select;
   } wcb_cfg_t;

   // spi slave states, gray along idle, header, data
   typedef enum logic [1:0] {
      WCB_SPI_IDLE = 2'b00,
      WCB_SPI_HDR = 2'b01,
      WCB_SPI_DATA = 2'b11,
      WCB_SPI_SKIP = 2'b10
   } wcb_spi_state_t;

endpackage

// file: wcb_mem.sv
// capture memory of 2048 words of 32 bits
// one write port, one registered read port, both on the core clock
`timescale 1ns/1ps
module wcb_mem
(
   input wire logic core_clk,
   input wire logic reset,
   input wire logic we,
   input wire logic [10:0] waddr,
   input wire logic [31:0] wdata,
   input wire logic [10:0] raddr,
   output logic [31:0] rdata
);

   logic [31:0] store [0:wcb_pkg::WCB_DEPTH-1];

   // array write, no reset so contents survive disable
   always_ff @(posedge core_clk)
   begin
      if (we)
      begin
         store[waddr] <= wdata;
      end
   end

   // registered read
   always_ff @(posedge core_clk or posedge reset)
   begin
      if (reset)
      begin
         rdata <= 32'h0000_0000;
      end
      else
      begin
         rdata <= store[raddr];
      end
   end

endmodule // wcb_mem

// file: wcb_capture_top.sv
// waveform capture buffer: fills the capture memory with sample sets and
// streams it out over an spi slave; spi pins come from another domain,
// config and sample strobes come from logic on core_clk
`timescale 1ns/1ps
module wcb_capture_top
(
   input wire logic core_clk,
   input wire logic reset,
   input wire wcb_pkg::wcb_cfg_t cfg,
   input wire logic rs_set_valid,
   input wire wcb_pkg::wcb_rs_set_t rs_set,
   input wire logic fr_set_valid,
   input wire wcb_pkg::wcb_fr_set_t fr_set,
   input wire logic full_flag_clear,
   output logic resampled_buffer_full_flag,
   output logic [11:0] last_filled_address,
   output logic [11:0] trigger_event_address,
   output logic capture_running,
   input wire logic spi_sclk,
   input wire logic spi_cs_n,
   input wire logic spi_mosi,
   output logic spi_miso,
   output logic spi_miso_oe_n
);

   logic cap_en_prev;
   logic cap_type;
   logic busy;
   logic [10:0] set_base;
   logic [2:0] wr_word;
   logic [6:0][31:0] hold;
   logic [6:0][31:0] rs_words;
   logic [6:0][31:0] fr_words;
   logic [31:0] rdata;

   // enable edges start and stop a capture
   wire en_rise = cfg.capture_enable & ~cap_en_prev;
   wire en_fall = ~cfg.capture_enable & cap_en_prev;
   wire is_rs = (cap_type == wcb_pkg::WCB_CAP_RESAMPLED);
   wire [2:0] last_word = is_rs ? wcb_pkg::WCB_RS_LAST_WORD
                                : wcb_pkg::WCB_FR_LAST_WORD;
   wire [10:0] fill_step = is_rs ? wcb_pkg::WCB_RS_STEP
                                 : wcb_pkg::WCB_FR_STEP;
   wire set_valid = is_rs ? rs_set_valid : fr_set_valid;
   wire set_done = busy & (wr_word == last_word);
   wire full_set = set_done & is_rs
      & (set_base == wcb_pkg::WCB_RS_LAST_SET);
   wire [15:0] neutral_rs = cfg.neutral_storage_enable ? rs_set.neutral
                                                       : wcb_pkg::WCB_SPARE;
   wire mem_we = busy;
   wire [10:0] mem_waddr = set_base + {8'h00, wr_word};

   // resampled word layout: voltage high, current low, neutral in word 3
   assign rs_words[0] = {rs_set.va, rs_set.ia};
   assign rs_words[1] = {rs_set.vb, rs_set.ib};
   assign rs_words[2] = {rs_set.vc, rs_set.ic};
   assign rs_words[3] = {wcb_pkg::WCB_SPARE, neutral_rs};
   assign rs_words[6:4] = '0; // nothing beyond word 3 in a resampled set

   // fixed-rate layout: one 32-bit word per channel, eighth word untouched
   assign fr_words = fr_set; // ia lands in word 0, neutral in word 6

   // capture control and set write sequencer
   always_ff @(posedge core_clk or posedge reset)
   begin
      if (reset)
      begin
         cap_en_prev <= 1'b0;
         cap_type <= wcb_pkg::WCB_CAP_RESAMPLED;
         capture_running <= 1'b0;
         busy <= 1'b0;
         set_base <= 11'h000;
         wr_word <= 3'h0;
      end
      else
      begin
         cap_en_prev <= cfg.capture_enable;
         if (en_rise)
         begin
            cap_type <= cfg.capture_type_select;
            capture_running <= 1'b1;
            busy <= 1'b0;
            set_base <= 11'h000; // first word, 0x800
         end
         else if (!cfg.capture_enable)
         begin
            capture_running <= 1'b0;
            busy <= 1'b0;
         end
         else if (busy)
         begin
            wr_word <= wr_word + 3'h1;
            if (set_done)
            begin
               busy <= 1'b0;
               set_base <= set_base + fill_step; // upward
               if (full_set)
                  capture_running <= 1'b0;
            end
         end
         else if (capture_running && set_valid)
         begin
            busy <= 1'b1;
            wr_word <= 3'h0;
         end
      end
   end

   // latch the arriving set so its words are written one per cycle
   always_ff @(posedge core_clk or posedge reset)
   begin
      if (reset)
      begin
         hold <= '0;
      end
      else if (!busy && capture_running && set_valid)
         hold <= is_rs ? rs_words : fr_words;
   end

   // sticky full flag, a set beats a clear in the same cycle
   always_ff @(posedge core_clk or posedge reset)
   begin
      if (reset)
      begin
         resampled_buffer_full_flag <= 1'b0;
      end
      else
         resampled_buffer_full_flag <= full_set
            | (resampled_buffer_full_flag & ~full_flag_clear);
   end

   // address status, reset when capture is disabled
   always_ff @(posedge core_clk or posedge reset)
   begin
      if (reset)
      begin
         last_filled_address <= wcb_pkg::WCB_LAST_ADDR_RESET;
         trigger_event_address <= wcb_pkg::WCB_TRIG_ADDR_RESET;
      end
      else if (en_fall)
      begin
         last_filled_address <= wcb_pkg::WCB_LAST_ADDR_RESET;
         trigger_event_address <= wcb_pkg::WCB_TRIG_ADDR_RESET;
      end
      else if (mem_we)
         last_filled_address <= wcb_pkg::WCB_BUF_BASE | {1'b0, mem_waddr};
   end

   logic sclk_meta, sclk_sync, sclk_prev;
   logic cs_meta, cs_sync;
   logic mosi_meta, mosi_sync;
   wcb_pkg::wcb_spi_state_t state;
   logic [15:0] hdr;
   logic [3:0] hdr_cnt;
   logic [4:0] bit_cnt;
   logic [2:0] ch;
   logic [10:0] set_ptr;
   logic half;
   logic single;
   logic [31:0] shreg;
   logic [6:0] mask;

   // next selected channel after c, bit 3 flags a wrap to the next set
   function automatic logic [3:0] wcb_next(input logic [6:0] m,
                                           input logic [2:0] c);
      logic [3:0] r;
      int k;
      int j;
      r = {1'b1, c};
      for (k = 7; k >= 1; k--)
      begin
         j = (int'(c) + k) % 7;
         if (m[j])
         begin
            r = {((int'(c) + k) >= 7), 3'(j)};
         end
      end
      return r;
   endfunction

   // two-flop synchronisers on the spi pins
   always_ff @(posedge core_clk or posedge reset)
   begin
      if (reset)
      begin
         sclk_meta <= 1'b1; // sclk idles high, so no false edge
         sclk_sync <= 1'b1;
         sclk_prev <= 1'b1;
         cs_meta <= 1'b1;
         cs_sync <= 1'b1;
         mosi_meta <= 1'b0;
         mosi_sync <= 1'b0;
      end
      else
      begin
         sclk_meta <= spi_sclk;
         sclk_sync <= sclk_meta;
         sclk_prev <= sclk_sync;
         cs_meta <= spi_cs_n;
         cs_sync <= cs_meta;
         mosi_meta <= spi_mosi;
         mosi_sync <= mosi_meta;
      end
   end

   // burst channel mask, same codes for either data type
   always_comb
   begin
      case (cfg.burst_channel_select)
         wcb_pkg::WCB_BURST_ALL: mask = cfg.neutral_storage_enable
            ? wcb_pkg::WCB_MASK_ALL : wcb_pkg::WCB_MASK_NO_NEUTRAL;
         wcb_pkg::WCB_BURST_PH_A: mask = wcb_pkg::WCB_MASK_PH_A;
         wcb_pkg::WCB_BURST_PH_B: mask = wcb_pkg::WCB_MASK_PH_B;
         wcb_pkg::WCB_BURST_PH_C: mask = wcb_pkg::WCB_MASK_PH_C;
         4'h8, 4'h9, 4'hA, 4'hB, 4'hC, 4'hD:
            mask = 7'(7'h01 << cfg.burst_channel_select[2:0]);
         default: mask = wcb_pkg::WCB_MASK_NEUTRAL;
      endcase
   end

   // sclk edges, header fields and the item under the read pointer
   wire sclk_rise = sclk_sync & ~sclk_prev;
   wire sclk_fall = ~sclk_sync & sclk_prev;
   wire rd_rs = (cfg.capture_type_select == wcb_pkg::WCB_CAP_RESAMPLED);
   wire [15:0] next_hdr = {hdr[14:0], mosi_sync};
   wire [11:0] hdr_addr = next_hdr[wcb_pkg::WCB_HDR_ADDR_MSB:
                                   wcb_pkg::WCB_HDR_ADDR_LSB];
   wire hdr_read = next_hdr[wcb_pkg::WCB_HDR_READ_BIT];
   wire hdr_single = (cfg.burst_channel_select == wcb_pkg::WCB_BURST_SINGLE);
   wire [3:0] first_ch = wcb_next(mask, wcb_pkg::WCB_CH_NEUTRAL);
   wire [3:0] nx = wcb_next(mask, ch);
   wire [10:0] rs_word = (ch == wcb_pkg::WCB_CH_NEUTRAL)
      ? wcb_pkg::WCB_NEUTRAL_WORD : {9'h000, ch[2:1]};
   wire [10:0] rd_addr = single ? set_ptr
      : rd_rs ? set_ptr + rs_word : set_ptr + {8'h00, ch};
   wire rs_high = single ? ~half
      : (ch[0] && ch != wcb_pkg::WCB_CH_NEUTRAL); // voltage high
   wire [15:0] rs_half = rs_high ? rdata[31:16] : rdata[15:0];
   wire [31:0] item = rd_rs ? {rs_half, 16'h0000} : rdata;
   wire [4:0] last_bit = rd_rs ? wcb_pkg::WCB_RS_LAST_BIT
                               : wcb_pkg::WCB_FR_LAST_BIT;
   wire [10:0] rd_step = rd_rs ? wcb_pkg::WCB_RS_STEP : wcb_pkg::WCB_FR_STEP;
   wire [10:0] start_ptr = hdr_single ? hdr_addr[10:0]
      : rd_rs ? {hdr_addr[10:2], 2'b00}
              : {hdr_addr[10:3], 3'b000};

   // spi slave: header in on rising sclk, data out on falling sclk
   always_ff @(posedge core_clk or posedge reset)
   begin
      if (reset)
      begin
         state <= wcb_pkg::WCB_SPI_IDLE;
         hdr <= 16'h0000;
         hdr_cnt <= 4'h0;
         bit_cnt <= 5'h00;
         ch <= 3'h0;
         set_ptr <= 11'h000;
         half <= 1'b0;
         single <= 1'b0;
         shreg <= 32'h0000_0000;
      end
      else if (cs_sync)
      begin
         state <= wcb_pkg::WCB_SPI_IDLE;
         hdr_cnt <= 4'h0;
      end
      else
      begin
         case (state)
            wcb_pkg::WCB_SPI_IDLE:
            begin
               state <= wcb_pkg::WCB_SPI_HDR;
               bit_cnt <= 5'h00;
               shreg <= 32'h0000_0000;
            end
            wcb_pkg::WCB_SPI_HDR:
            begin
               if (sclk_rise)
               begin
                  hdr <= next_hdr;
                  hdr_cnt <= hdr_cnt + 4'h1;
                  if (hdr_cnt == wcb_pkg::WCB_HDR_LAST_BIT)
                  begin
                     state <= hdr_read ? wcb_pkg::WCB_SPI_DATA
                                       : wcb_pkg::WCB_SPI_SKIP;
                     single <= hdr_single;
                     set_ptr <= start_ptr;
                     ch <= first_ch[2:0];
                     half <= 1'b0;
                  end
               end
            end
            wcb_pkg::WCB_SPI_DATA:
            begin
               if (sclk_fall)
               begin
                  bit_cnt <= (bit_cnt == last_bit) ? 5'h00
                                                   : bit_cnt + 5'h01;
                  if (bit_cnt == 5'h00)
                  begin
                     shreg <= item; // stream without new header
                     if (single)
                        half <= ~half; // same word repeats
                     else
                     begin
                        ch <= nx[2:0];
                        if (nx[3])
                           set_ptr <= set_ptr + rd_step;
                     end
                  end
                  else
                  begin
                     shreg <= {shreg[30:0], 1'b0};
                  end
               end
            end
            default: state <= wcb_pkg::WCB_SPI_SKIP;
         endcase
      end
   end

   // miso from the shift register, driven only while selected
   assign spi_miso = shreg[31];
   assign spi_miso_oe_n = cs_sync;

   // capture memory
   wcb_mem i_wcb_mem
   (
      .core_clk(core_clk),
      .reset(reset),
      .we(mem_we),
      .waddr(mem_waddr),
      .wdata(hold[wr_word]),
      .raddr(rd_addr),
      .rdata(rdata)
   );

endmodule // wcb_capture_top

// file: wcb_capture_asserts.sv
// port-level assertions of the waveform capture buffer
// assumes one core clock domain and an async active-high reset
`timescale 1ns/1ps
module wcb_capture_asserts
(
   input wire logic core_clk,
   input wire logic reset,
   input wire wcb_pkg::wcb_cfg_t cfg,
   input wire logic full_flag_clear,
   input wire logic resampled_buffer_full_flag,
   input wire logic [11:0] last_filled_address,
   input wire logic [11:0] trigger_event_address,
   input wire logic capture_running
);
   // all properties sample on the core clock and sleep in reset
   default clocking cb @(posedge core_clk);
   endclocking
   default disable iff (reset);

   a_trig_zero:
      assert property (trigger_event_address == 12'h000)
      else $error("trigger address left its reset value");
   a_last_clear:
      assert property ($fell(cfg.capture_enable) |->
         ##[1:2] last_filled_address == 12'h000)
      else $error("last address kept after disable");
   a_first_word:
      assert property (last_filled_address != 12'h000 &&
         $past(last_filled_address) == 12'h000 |->
         last_filled_address == 12'h800)
      else $error("fill did not start at first word");
   a_addr_step:
      assert property (!cfg.capture_type_select &&
         $changed(last_filled_address) &&
         $past(last_filled_address) != 12'h000 &&
         last_filled_address != 12'h000 |->
         last_filled_address == $past(last_filled_address) + 12'h001)
      else $error("resampled fill skipped a word");
   a_full_sticky:
      assert property (resampled_buffer_full_flag && !full_flag_clear
         |=> resampled_buffer_full_flag)
      else $error("full flag dropped without clear");
   a_full_addr:
      assert property ($rose(resampled_buffer_full_flag) |->
         ##[0:2] last_filled_address == 12'hFFF)
      else $error("full flag before last word");
   a_full_halt:
      assert property ($rose(resampled_buffer_full_flag) |->
         ##[0:2] !capture_running)
      else $error("capture kept running when full");
   a_run_start:
      assert property ($rose(cfg.capture_enable) |-> ##[1:3] capture_running)
      else $error("enable did not start capture");
   a_run_off:
      assert property (!cfg.capture_enable [*3] |-> !capture_running)
      else $error("capture running while disabled");
endmodule // wcb_capture_asserts

bind wcb_capture_top wcb_capture_asserts i_wcb_capture_asserts
(
   .core_clk(core_clk),
   .reset(reset),
   .cfg(cfg),
   .full_flag_clear(full_flag_clear),
   .resampled_buffer_full_flag(resampled_buffer_full_flag),
   .last_filled_address(last_filled_address),
   .trigger_event_address(trigger_event_address),
   .capture_running(capture_running)
);

// file: wcb_spi_host.sv
// spi master model standing in for the host processor
// clock idles high and runs at 64 ns only inside frames
`timescale 1ns/1ps
module wcb_spi_host
(
   output logic spi_sclk,
   output logic spi_cs_n,
   output logic spi_mosi,
   input wire logic spi_miso
);
   // idle: deselected, clock parked high
   initial
   begin
      spi_sclk = 1'b1;
      spi_cs_n = 1'b1;
      spi_mosi = 1'b0;
   end

   // select and send one 16-bit header, msb first
   task automatic start(input logic [11:0] addr, input logic rd);
      logic [15:0] hdr;
      hdr = {addr, rd, 3'b000};
      #0.5;
      spi_cs_n = 1'b0;
      #64;
      for (int i = 15; i >= 0; i--)
      begin
         spi_sclk = 1'b0;
         spi_mosi = hdr[i];
         #32;
         spi_sclk = 1'b1;
         #32;
      end
   endtask

   // clock in one item; mosi carries a toggling filler
   task automatic get(input int nbits, output logic [31:0] data);
      data = '0;
      for (int i = 0; i < nbits; i++)
      begin
         spi_sclk = 1'b0;
         spi_mosi = ~spi_mosi;
         #32;
         spi_sclk = 1'b1;
         data = {data[30:0], spi_miso};
         #32;
      end
   endtask

   // deselect; the released data line shows the inverse level
   task automatic stop();
      spi_cs_n = 1'b1;
      spi_mosi = ~spi_mosi;
      #128;
   endtask
endmodule // wcb_spi_host

// file: wcb_capture_top_test.sv
// self-checking bench of the waveform capture buffer
// drives the core side directly and the spi side through the host model
`timescale 1ns/1ps
module wcb_capture_top_test;
   logic core_clk = 1'b0;
   logic reset = 1'b1;
   wcb_pkg::wcb_cfg_t cfg = '0;
   logic rs_set_valid = 1'b0;
   wcb_pkg::wcb_rs_set_t rs_set = '0;
   logic fr_set_valid = 1'b0;
   wcb_pkg::wcb_fr_set_t fr_set = '0;
   logic full_flag_clear = 1'b0;
   logic full_flag;
   logic [11:0] last_addr;
   logic [11:0] trig_addr;
   logic running;
   logic sclk;
   logic cs_n;
   logic mosi;
   logic miso;
   logic miso_oe_n;
   logic host_miso;
   int n_fail = 0;
   int checked = 0;

   // 200 MHz core clock
   always #2.5 core_clk = ~core_clk;

   wcb_capture_top i_wcb_capture_top
   (
      .core_clk(core_clk),
      .reset(reset),
      .cfg(cfg),
      .rs_set_valid(rs_set_valid),
      .rs_set(rs_set),
      .fr_set_valid(fr_set_valid),
      .fr_set(fr_set),
      .full_flag_clear(full_flag_clear),
      .resampled_buffer_full_flag(full_flag),
      .last_filled_address(last_addr),
      .trigger_event_address(trig_addr),
      .capture_running(running),
      .spi_sclk(sclk),
      .spi_cs_n(cs_n),
      .spi_mosi(mosi),
      .spi_miso(miso),
      .spi_miso_oe_n(miso_oe_n)
   );

   wcb_spi_host i_wcb_spi_host
   (
      .spi_sclk(sclk),
      .spi_cs_n(cs_n),
      .spi_mosi(mosi),
      .spi_miso(host_miso)
   );

   // a released miso line shows the inverse level at the host
   assign host_miso = miso_oe_n ? ~miso : miso;

   // sample of capture g, set k, burst channel c
   function automatic logic [15:0] rsv(int g, int k, int c);
      return {g[1:0], c[2:0], k[10:0]};
   endfunction

   // resampled memory word w as it should be laid out
   function automatic logic [31:0] rsw(int g, int w, logic nen);
      int k = w / 4;
      int p = w % 4;
      if (p == 3)
         return {16'h0000, nen ? rsv(g, k, 6) : 16'h0000};
      return {rsv(g, k, 2 * p + 1), rsv(g, k, 2 * p)};
   endfunction

   // fixed-rate sample of set k, channel c
   function automatic logic [31:0] frv(int g, int k, int c);
      return {8'hA5, 5'h00, c[2:0], rsv(g, k, c)};
   endfunction

   // channels picked by a burst select code
   function automatic logic [6:0] chans(logic [3:0] code, logic nen);
      if (code == 4'h0)
         return nen ? 7'h7F : 7'h3F;
      if (code inside {[4'h1:4'h3]})
         return 7'h03 << (2 * (code - 4'h1));
      if (code inside {[4'h8:4'hD]})
         return 7'h01 << (code - 4'h8);
      return 7'h40;
   endfunction

   // compare one value and count it
   task automatic chk(input logic [31:0] got, input logic [31:0] exp,
      input string what);
      checked++;
      if (got !== exp)
      begin
         n_fail++;
         $display("wrong value at %0t: %s got %h exp %h", $time, what,
            got, exp);
      end
   endtask

   task automatic ticks(input int n);
      repeat (n) @(posedge core_clk);
   endtask

   task automatic end_sim();
      $display("comparisons %0d, mismatches %0d", checked, n_fail);
      if (n_fail == 0 && checked > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask

   // host sequence: disable, choose type and neutral storage, enable
   task automatic cap(input logic typ, input logic nen);
      @(posedge core_clk);
      cfg.capture_enable <= 1'b0;
      @(posedge core_clk);
      cfg.capture_type_select <= typ;
      cfg.neutral_storage_enable <= nen;
      @(posedge core_clk);
      cfg.capture_enable <= 1'b1;
      ticks(3);
   endtask

   // offer n sample sets starting at set k0, nine cycles apart
   task automatic put(input logic typ, input int g, input int k0,
      input int n);
      logic [111:0] rv;
      logic [223:0] fv;
      for (int k = k0; k < k0 + n; k++)
      begin
         for (int c = 0; c < 7; c++)
         begin
            rv[16 * c +: 16] = rsv(g, k, c);
            fv[32 * c +: 32] = frv(g, k, c);
         end
         rs_set <= rv;
         fr_set <= fv;
         rs_set_valid <= !typ;
         fr_set_valid <= typ;
         @(posedge core_clk);
         rs_set_valid <= 1'b0;
         fr_set_valid <= 1'b0;
         ticks(8);
      end
   endtask

   // one burst read of n items and their comparison
   task automatic rd(input logic [3:0] code, input logic [11:0] addr,
      input int n, input int g, input logic nen);
      logic fix;
      int k;
      int c;
      logic [31:0] got;
      logic [31:0] exp;
      logic [6:0] m;
      fix = cfg.capture_type_select;
      m = chans(code, nen);
      @(posedge core_clk);
      cfg.burst_channel_select <= code;
      ticks(2);
      k = fix ? addr[10:3] : addr[10:2];
      c = -1;
      i_wcb_spi_host.start(addr, 1'b1);
      for (int i = 0; i < n; i++)
      begin
         do
         begin
            c++;
            if (c == 7)
            begin
               c = 0;
               k = (k + 1) % (fix ? 256 : 512);
            end
         end
         while (!m[c]);
         i_wcb_spi_host.get(fix ? 32 : 16, got);
         if (code == 4'hF && fix)
            exp = frv(g, addr[10:3], addr[2:0]);
         else if (code == 4'hF)
         begin
            exp = rsw(g, addr[10:0], nen);
            exp = (i % 2) ? exp[15:0] : exp[31:16];
         end
         else if (fix)
            exp = frv(g, k, c);
         else
         begin
            exp = rsw(g, 4 * k + c / 2, nen);
            exp = c[0] ? exp[31:16] : exp[15:0];
         end
         chk(got, exp, "burst item");
      end
      i_wcb_spi_host.stop();
   endtask

   task automatic t_reset();
      chk({full_flag, running, miso_oe_n}, 32'h1, "idle outputs");
      chk(last_addr, 12'h000, "last address");
      chk(trig_addr, 12'h000, "trigger address");
      $display("t_reset done");
   endtask

   task automatic t_fill();
      cap(1'b0, 1'b1);
      put(1'b0, 0, 0, 1);
      chk(last_addr, 12'h803, "first set");
      put(1'b0, 0, 1, 511);
      chk({full_flag, running}, 32'h2, "full");
      chk(last_addr, 12'hFFF, "last word");
      put(1'b0, 3, 0, 1);
      chk(last_addr, 12'hFFF, "set after full");
      full_flag_clear <= 1'b1;
      @(posedge core_clk);
      full_flag_clear <= 1'b0;
      cfg.capture_enable <= 1'b0;
      ticks(3);
      chk({full_flag, last_addr}, 32'h0, "after disable");
      $display("t_fill done");
   endtask

   task automatic t_codes();
      for (int i = 0; i < 16; i++)
         if (i < 4 || i > 7)
            rd(i[3:0], 12'h805, (i == 0) ? 9 : 3, 0, 1'b1);
      rd(4'h1, 12'hFFE, 4, 0, 1'b1);
      $display("t_codes done");
   endtask

   task automatic t_fresh();
      cap(1'b0, 1'b0);
      put(1'b0, 1, 0, 2);
      rd(4'h0, 12'h800, 7, 1, 1'b0);
      rd(4'hE, 12'h802, 2, 1, 1'b0);
      rd(4'hF, 12'h803, 2, 1, 1'b0);
      @(posedge core_clk);
      cfg.capture_enable <= 1'b0;
      ticks(3);
      rd(4'hF, 12'h801, 2, 1, 1'b0);
      $display("t_fresh done");
   endtask

   task automatic t_fixed();
      cap(1'b1, 1'b1);
      put(1'b1, 2, 0, 2);
      chk(last_addr, 12'h80E, "fixed fill");
      rd(4'h0, 12'h801, 8, 2, 1'b1);
      rd(4'hF, 12'h801, 2, 2, 1'b1);
      rd(4'h3, 12'h80F, 2, 2, 1'b1);
      $display("t_fixed done");
   endtask

   // reset, then the scenarios in turn
   initial
   begin
      repeat (12) @(posedge core_clk);
      reset <= 1'b0;
      ticks(3);
      t_reset();
      t_fill();
      t_codes();
      t_fresh();
      t_fixed();
      end_sim();
   end
endmodule // wcb_capture_top_test
